// File: src/tlic_top.sv
// two-level prioritised interrupt controller with its enable and priority registers
`timescale 1ns/1ps
module tlic_top (
  input wire logic ref_clk,
  input wire logic reset,
  // special-register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wr,
  input wire logic bit_rd,
  input wire logic bit_wdata,
  output logic bit_rdata,
  // peripheral pending flags
  input tlic_pkg::tlic_src_flags_t src_flags,
  // core handshake
  input wire logic instr_done,
  input wire logic instr_is_return_from_interrupt,
  input wire logic cpu_stall,
  output logic call_active,
  output logic call_done,
  output logic [15:0] call_vector,
  output logic in_service_low,
  output logic in_service_high
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] interrupt_enable_r;
  logic [6:0] priority_reg_main_r;
  logic [7:0] enable_reg_ext_a_r;
  logic [7:0] priority_reg_ext_a_r;
  logic [7:0] enable_reg_ext_b_r;
  logic [7:0] priority_reg_ext_b_r;
  logic [7:0] sfr_rdata_r;
  logic bit_rdata_r;

  // byte write wins over a bit write in the same cycle
  function automatic logic [7:0] reg_write(
    input logic [7:0] cur,
    input logic [7:0] reg_addr,
    input logic bit_ok
  );
    logic [7:0] nxt;
    nxt = cur;
    if (bit_ok && bit_wr && (bit_addr[7:3] == reg_addr[7:3])) begin
      nxt[bit_addr[2:0]] = bit_wdata;
    end
    if (sfr_wr && (sfr_addr == reg_addr)) begin
      nxt = sfr_wdata;
    end
    return nxt;
  endfunction

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      interrupt_enable_r <= tlic_pkg::RST_IE;
    end else begin
      interrupt_enable_r <= reg_write(interrupt_enable_r, tlic_pkg::ADDR_IE, 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      priority_reg_main_r <= tlic_pkg::RST_IP;
    end else begin
      priority_reg_main_r <= 7'(reg_write({1'b1, priority_reg_main_r}, tlic_pkg::ADDR_IP,
                                          1'b1));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enable_reg_ext_a_r <= tlic_pkg::RST_EXT_A;
      priority_reg_ext_a_r <= tlic_pkg::RST_EXT_A;
    end else begin
      enable_reg_ext_a_r <= reg_write(enable_reg_ext_a_r, tlic_pkg::ADDR_ENABLE_REG_EXT_A, 1'b0);
      priority_reg_ext_a_r <= reg_write(priority_reg_ext_a_r, tlic_pkg::ADDR_PRIORITY_REG_EXT_A, 1'b0);
    end
  end

  // reserved bits of the second extension pair never store
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enable_reg_ext_b_r <= tlic_pkg::RST_EXT_B;
      priority_reg_ext_b_r <= tlic_pkg::RST_EXT_B;
    end else begin
      enable_reg_ext_b_r <= reg_write(enable_reg_ext_b_r, tlic_pkg::ADDR_ENABLE_REG_EXT_B, 1'b0)
                            & tlic_pkg::EXT_B_MASK;
      priority_reg_ext_b_r <= reg_write(priority_reg_ext_b_r, tlic_pkg::ADDR_PRIORITY_REG_EXT_B, 1'b0)
                              & tlic_pkg::EXT_B_MASK;
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    logic [7:0] v;
    case (addr)
      tlic_pkg::ADDR_IE: v = interrupt_enable_r;
      tlic_pkg::ADDR_IP: v = tlic_pkg::IP_TOP_READ | {1'b0, priority_reg_main_r};
      tlic_pkg::ADDR_ENABLE_REG_EXT_A: v = enable_reg_ext_a_r;
      tlic_pkg::ADDR_PRIORITY_REG_EXT_A: v = priority_reg_ext_a_r;
      tlic_pkg::ADDR_ENABLE_REG_EXT_B: v = enable_reg_ext_b_r;
      tlic_pkg::ADDR_PRIORITY_REG_EXT_B: v = priority_reg_ext_b_r;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_r <= reg_read(sfr_addr);
    end
  end

  // only the two byte-aligned registers are bit-addressable
  logic [7:0] bit_byte;
  assign bit_byte = reg_read({bit_addr[7:3], 3'b000});

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bit_rdata_r <= 1'b0;
    end else if (bit_rd) begin
      bit_rdata_r <= bit_byte[bit_addr[2:0]];
    end
  end

  assign sfr_rdata = sfr_rdata_r;
  assign bit_rdata = bit_rdata_r;

  // ---------------------------------------------------------------
  // source vectors in fixed order
  // ---------------------------------------------------------------
  logic [tlic_pkg::NUM_SRC-1:0] pending;
  logic [tlic_pkg::NUM_SRC-1:0] enable;
  logic [tlic_pkg::NUM_SRC-1:0] prio_high;

  // flags are level inputs from their peripherals; nothing here clears them
  always_comb begin
    pending[0] = src_flags.external_input_zero;
    pending[1] = src_flags.timer0_overflow_flag;
    pending[2] = src_flags.external_input_one;
    pending[3] = src_flags.timer1_overflow_flag;
    pending[4] = src_flags.uart0;
    pending[5] = src_flags.timer2_low_overflow_flag
                 | src_flags.timer2_high_overflow_flag;
    pending[6] = src_flags.transfer_complete_flag | src_flags.write_collision_flag
                 | src_flags.mode_fault_flag | src_flags.receive_overrun_flag;
    pending[7] = src_flags.smbus0;
    pending[8] = src_flags.usb0;
    pending[9] = src_flags.adc_window;
    pending[10] = src_flags.adc_conv_done;
    pending[11] = src_flags.counter_array;
    pending[12] = src_flags.comparator0;
    pending[13] = src_flags.comparator1;
    pending[14] = src_flags.timer3;
    pending[15] = src_flags.vbus_level;
    pending[16] = src_flags.uart1;
    pending[tlic_pkg::RESERVED_ORDER] = 1'b0;
    pending[18] = src_flags.port_match;
  end

  // enable and priority bits laid out by order number
  assign enable = {enable_reg_ext_b_r[3], 1'b0, enable_reg_ext_b_r[1:0],
                   enable_reg_ext_a_r, interrupt_enable_r[6:0]};
  assign prio_high = {priority_reg_ext_b_r[3], 1'b0, priority_reg_ext_b_r[1:0],
                      priority_reg_ext_a_r, priority_reg_main_r};

  // ---------------------------------------------------------------
  // arbitration, one decode per clock
  // ---------------------------------------------------------------
  logic active_low_r;
  logic active_high_r;
  logic allow_low;
  logic allow_high;
  tlic_pkg::tlic_req_t arb_req;
  tlic_pkg::tlic_req_t req_r;

  assign allow_high = !active_high_r;
  assign allow_low = !active_high_r && !active_low_r;

  tlic_arbiter #(
    .NUM_SRC(tlic_pkg::NUM_SRC)
  ) u_arbiter (
    .pending(pending),
    .enable(enable),
    .prio_high(prio_high),
    .global_en(interrupt_enable_r[tlic_pkg::GLOBAL_EN_BIT]),
    .allow_low(allow_low),
    .allow_high(allow_high),
    .req(arb_req)
  );

  // detect stage: the registered decode is the one detect cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_r <= '0;
    end else begin
      req_r <= arb_req;
    end
  end

  // ---------------------------------------------------------------
  // instruction boundary and call sequencing
  // ---------------------------------------------------------------
  tlic_pkg::tlic_state_t state_r;
  logic return_from_interrupt_hold_r;
  logic take;
  logic return_from_interrupt_seen;
  logic seq_busy;
  logic seq_done;
  logic [15:0] call_vector_r;

  // a return must be followed by one whole instruction before the next call
  assign return_from_interrupt_seen = instr_done && instr_is_return_from_interrupt && !cpu_stall;
  assign take = (state_r == tlic_pkg::TLIC_IDLE) && instr_done && !instr_is_return_from_interrupt
                && !return_from_interrupt_hold_r && !cpu_stall && req_r.valid;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      return_from_interrupt_hold_r <= 1'b0;
    end else if (return_from_interrupt_seen) begin
      return_from_interrupt_hold_r <= 1'b1;
    end else if (instr_done && !cpu_stall) begin
      return_from_interrupt_hold_r <= 1'b0;
    end
  end

  // push the level on a call, pop the highest on a return
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_low_r <= 1'b0;
      active_high_r <= 1'b0;
    end else if (take) begin
      if (req_r.high) begin
        active_high_r <= 1'b1;
      end else begin
        active_low_r <= 1'b1;
      end
    end else if (return_from_interrupt_seen) begin
      if (active_high_r) begin
        active_high_r <= 1'b0;
      end else begin
        active_low_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= tlic_pkg::TLIC_IDLE;
    end else begin
      case (state_r)
        tlic_pkg::TLIC_IDLE: begin
          if (take) begin
            state_r <= tlic_pkg::TLIC_CALL;
          end
        end
        tlic_pkg::TLIC_CALL: begin
          if (seq_done) begin
            state_r <= tlic_pkg::TLIC_IDLE;
          end
        end
        default: begin
          state_r <= tlic_pkg::TLIC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      call_vector_r <= tlic_pkg::VEC_RESET;
    end else if (take) begin
      call_vector_r <= tlic_pkg::VEC_BASE
                       + {8'h00, req_r.order, 3'b000};
    end
  end

  tlic_call_seq #(
    .CALL_CYCLES(tlic_pkg::CALL_CYCLES)
  ) u_call_seq (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(take),
    .stall(cpu_stall),
    .busy(seq_busy),
    .done(seq_done)
  );

  assign call_active = seq_busy;
  assign call_done = seq_done;
  assign call_vector = call_vector_r;
  assign in_service_low = active_low_r;
  assign in_service_high = active_high_r;

endmodule

// File: pkg/tlic_pkg.sv
// constants and types shared by the two-level interrupt controller
package tlic_pkg;

  // ---------------------------------------------------------------
  // source set
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 19;
  localparam int ORDER_W = 5;
  localparam int RESERVED_ORDER = 17;

  // ---------------------------------------------------------------
  // special-register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IE = 8'hA8;
  localparam logic [7:0] ADDR_IP = 8'hB8;
  localparam logic [7:0] ADDR_ENABLE_REG_EXT_A = 8'hE6;
  localparam logic [7:0] ADDR_PRIORITY_REG_EXT_A = 8'hF6;
  localparam logic [7:0] ADDR_ENABLE_REG_EXT_B = 8'hE7;
  localparam logic [7:0] ADDR_PRIORITY_REG_EXT_B = 8'hF7;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_IE = 8'h00;
  localparam logic [6:0] RST_IP = 7'h00;
  localparam logic [7:0] RST_EXT_A = 8'h00;
  localparam logic [7:0] RST_EXT_B = 8'h00;
  localparam logic [7:0] IP_TOP_READ = 8'h80;
  localparam logic [7:0] EXT_B_MASK = 8'h0B;
  localparam int GLOBAL_EN_BIT = 7;

  // ---------------------------------------------------------------
  // vectors and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 5;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic port_match;
    logic uart1;
    logic vbus_level;
    logic timer3;
    logic comparator1;
    logic comparator0;
    logic counter_array;
    logic adc_conv_done;
    logic adc_window;
    logic usb0;
    logic smbus0;
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
    logic timer2_high_overflow_flag;
    logic timer2_low_overflow_flag;
    logic uart0;
    logic timer1_overflow_flag;
    logic external_input_one;
    logic timer0_overflow_flag;
    logic external_input_zero;
  } tlic_src_flags_t;

  typedef struct packed {
    logic valid;
    logic high;
    logic [ORDER_W-1:0] order;
  } tlic_req_t;

  typedef enum logic [1:0] {
    TLIC_IDLE = 2'b00,
    TLIC_CALL = 2'b01
  } tlic_state_t;

endpackage

// File: src/tlic_arbiter.sv
// two-level fixed-order arbiter over the gated pending vector
`timescale 1ns/1ps
module tlic_arbiter #(
  parameter int NUM_SRC = 19
) (
  input wire logic [NUM_SRC-1:0] pending,
  input wire logic [NUM_SRC-1:0] enable,
  input wire logic [NUM_SRC-1:0] prio_high,
  input wire logic global_en,
  input wire logic allow_low,
  input wire logic allow_high,
  output tlic_pkg::tlic_req_t req
);

  generate
    if (NUM_SRC < 1 || NUM_SRC > (1 << tlic_pkg::ORDER_W)) begin : g_bad
      $error("tlic_arbiter: source count does not fit the order field");
    end
  endgenerate

  // lowest index wins, so scan from the top down
  function automatic logic [tlic_pkg::ORDER_W-1:0] lowest(input logic [NUM_SRC-1:0] v);
    logic [tlic_pkg::ORDER_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = tlic_pkg::ORDER_W'(i);
      end
    end
    return idx;
  endfunction

  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] hi_cand;
  logic [NUM_SRC-1:0] lo_cand;

  always_comb begin
    eligible = pending & enable & {NUM_SRC{global_en}};
    hi_cand = eligible & prio_high & {NUM_SRC{allow_high}};
    lo_cand = eligible & ~prio_high & {NUM_SRC{allow_low}};
    req.valid = |hi_cand || |lo_cand;
    req.high = |hi_cand;
    req.order = (|hi_cand) ? lowest(hi_cand) : lowest(lo_cand);
  end

endmodule

// File: src/tlic_call_seq.sv
// long-call sequencer: counts the call cycles, frozen while the core stalls
`timescale 1ns/1ps
module tlic_call_seq #(
  parameter int CALL_CYCLES = 5
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic stall,
  output logic busy,
  output logic done
);

  generate
    if (CALL_CYCLES < 1 || CALL_CYCLES > 255) begin : g_bad
      $error("tlic_call_seq: call length out of range");
    end
  endgenerate

  localparam logic [7:0] LAST = 8'(CALL_CYCLES - 1);

  logic [7:0] cnt_r;
  logic busy_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= 8'h00;
    end else if (busy_r && !stall) begin
      if (cnt_r == LAST) begin
        busy_r <= 1'b0;
      end
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign busy = busy_r;
  assign done = busy_r && !stall && (cnt_r == LAST);

endmodule

// File: sim/tlic_props.sv
// assertion checker for the interrupt controller's core-side ports
`timescale 1ns/1ps
module tlic_props (
  input wire logic ref_clk,
  input wire logic reset,
  input tlic_pkg::tlic_src_flags_t src_flags,
  input wire logic instr_done,
  input wire logic instr_is_return_from_interrupt,
  input wire logic cpu_stall,
  input wire logic call_active,
  input wire logic call_done,
  input wire logic [15:0] call_vector,
  input wire logic in_service_low,
  input wire logic in_service_high
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  call_len_a: assert property ($rose(call_active) ##0 !cpu_stall [*5] |-> call_done)
    else $error("call not done in its fifth cycle");
  done_end_a: assert property (call_done && !cpu_stall |=> !call_active)
    else $error("call still active after done");
  vector_form_a: assert property ($rose(call_active) |-> call_vector[2:0] == 3'h3
    && call_vector <= 16'h0093 && call_vector != 16'h008B)
    else $error("call vector outside the table");
  vector_hold_a: assert property (call_active && !$rose(call_active) |-> $stable(call_vector))
    else $error("call vector moved during a call");
  flag_cause_a: assert property ($rose(call_active) |-> $past(|src_flags, 2))
    else $error("call without a pending flag");
  high_keep_a: assert property ($rose(call_active) |-> !$past(in_service_high))
    else $error("high routine preempted");
  low_preempt_a: assert property ($rose(call_active) && $past(in_service_low) |-> in_service_high)
    else $error("low routine preempted by low request");
  return_from_interrupt_gap_a: assert property (instr_done && instr_is_return_from_interrupt && !cpu_stall
    |=> !$rose(call_active) ##1 !$rose(call_active))
    else $error("call taken without one instruction after return");
  boundary_take_a: assert property ($rose(call_active)
    |-> $past(instr_done && !instr_is_return_from_interrupt && !cpu_stall))
    else $error("call started off an instruction boundary");
  stall_hold_a: assert property (cpu_stall && call_active |-> !call_done ##1 call_active)
    else $error("stall did not freeze the call");
endmodule

// File: sim/tlic_core_model.sv
// processor core model: instructions of one or more cycles, returns and stalls on command
`timescale 1ns/1ps
module tlic_core_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic call_active,
  input wire logic return_from_interrupt_cmd,
  input wire logic stall_cmd,
  input wire logic busy_cmd,
  output logic instr_done,
  output logic instr_is_return_from_interrupt,
  output logic cpu_stall
);
  initial begin
    instr_done = 1'b0;
    instr_is_return_from_interrupt = 1'b0;
    cpu_stall = 1'b0;
  end
  // no instruction retires while the call runs or the core is stalled
  always @(negedge ref_clk) begin
    cpu_stall <= stall_cmd;
    // busy_cmd keeps the current instruction running: no boundary this cycle
    instr_done <= !reset && !call_active && !stall_cmd && !busy_cmd;
    instr_is_return_from_interrupt <= return_from_interrupt_cmd && !call_active && !stall_cmd && !busy_cmd;
  end
endmodule

// File: sim/tlic_top_tb.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module tlic_top_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] bit_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic bit_wr = 1'b0;
  logic bit_rd = 1'b0;
  logic bit_wdata = 1'b0;
  logic return_from_interrupt_cmd = 1'b0;
  logic stall_cmd = 1'b0;
  logic busy_cmd = 1'b0;
  logic [21:0] fl = 22'h00_0000;
  logic [7:0] sfr_rdata;
  logic [15:0] call_vector;
  logic bit_rdata, instr_done, instr_is_return_from_interrupt, cpu_stall;
  logic call_active, call_done, in_service_low, in_service_high;
  int fails = 0;
  int samples_checked = 0;

  always #12.5 ref_clk = ~ref_clk;

  tlic_top tlic_top_inst (.ref_clk(ref_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata),
    .bit_rdata(bit_rdata), .src_flags(tlic_pkg::tlic_src_flags_t'(fl)),
    .instr_done(instr_done), .instr_is_return_from_interrupt(instr_is_return_from_interrupt), .cpu_stall(cpu_stall),
    .call_active(call_active), .call_done(call_done), .call_vector(call_vector),
    .in_service_low(in_service_low), .in_service_high(in_service_high));

  tlic_core_model tlic_core_model_inst (.ref_clk(ref_clk), .reset(reset),
    .call_active(call_active), .return_from_interrupt_cmd(return_from_interrupt_cmd), .stall_cmd(stall_cmd),
    .busy_cmd(busy_cmd), .instr_done(instr_done), .instr_is_return_from_interrupt(instr_is_return_from_interrupt),
    .cpu_stall(cpu_stall));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(negedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(negedge ref_clk);
    sfr_rd <= 1'b0;
    @(negedge ref_clk);
    chk(16'(sfr_rdata), 16'(e));
  endtask

  task automatic bwr(input logic [7:0] a, input logic d);
    @(negedge ref_clk);
    bit_addr <= a;
    bit_wdata <= d;
    bit_wr <= 1'b1;
    @(negedge ref_clk);
    bit_wr <= 1'b0;
  endtask

  task automatic brd(input logic [7:0] a, input logic e);
    @(negedge ref_clk);
    bit_addr <= a;
    bit_rd <= 1'b1;
    @(negedge ref_clk);
    bit_rd <= 1'b0;
    @(negedge ref_clk);
    chk(16'(bit_rdata), 16'(e));
  endtask

  task automatic return_from_interrupt();
    @(negedge ref_clk);
    return_from_interrupt_cmd <= 1'b1;
    @(negedge ref_clk);
    return_from_interrupt_cmd <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  // lat 0 skips the latency check; st stalls the core that many call cycles
  task automatic take(input logic [15:0] v, input int lat, input int st);
    int n;
    int m;
    n = 0;
    m = 0;
    while (call_active !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    chk(call_vector, v);
    if (lat > 0) chk(16'(n), 16'(lat));
    stall_cmd <= (st > 0);
    while (call_active === 1'b1 && m < 40) begin
      @(negedge ref_clk);
      m++;
      if (m == st) stall_cmd <= 1'b0;
    end
    chk(16'(m), 16'(5 + st));
  endtask

  task automatic quiet(input int n);
    int m;
    m = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if (call_active !== 1'b0) m++;
    end
    chk(16'(m), 16'h0000);
  endtask

  task automatic s_regs();
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'h80);
    rd(8'hF6, 8'h00);
    wr(8'hF7, 8'hFF);
    rd(8'hF7, 8'h0B);
    wr(8'hF7, 8'h00);
    wr(8'hA8, 8'h5A);
    rd(8'hA8, 8'h5A);
    bwr(8'hAF, 1'b1);
    brd(8'hAE, 1'b1);
    rd(8'hA8, 8'hDA);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
  endtask

  task automatic s_each();
    int o;
    wr(8'hA8, 8'hFF);
    wr(8'hE6, 8'hFF);
    wr(8'hE7, 8'h0B);
    for (int i = 0; i < 22; i++) begin
      o = i < 5 ? i : i < 7 ? 5 : i < 11 ? 6 : i < 21 ? i - 4 : 18;
      fl <= 22'h00_0001 << i;
      take(16'h0003 + 16'(o * 8), 2, 0);
      chk(16'(in_service_low), 16'h0001);
      fl <= 22'h00_0000;
      return_from_interrupt();
    end
  endtask

  task automatic s_gate();
    wr(8'hA8, 8'h01);
    fl <= 22'h00_0001;
    quiet(20);
    wr(8'hA8, 8'h80);
    quiet(20);
    bwr(8'hA8, 1'b1);
    take(16'h0003, 0, 0);
    fl <= 22'h00_0000;
    return_from_interrupt();
  endtask

  task automatic s_prio();
    wr(8'hA8, 8'hFF);
    wr(8'hB8, 8'h08);
    fl <= 22'h00_0009;
    take(16'h001B, 2, 0);
    chk(16'(in_service_high), 16'h0001);
    quiet(12);
    fl <= 22'h00_0001;
    return_from_interrupt();
    take(16'h0003, 0, 0);
    fl <= 22'h00_0006;
    return_from_interrupt();
    // flags already up: only the one instruction after the return is left
    take(16'h000B, 1, 0);
    fl <= 22'h00_0004;
    return_from_interrupt();
    take(16'h0013, 0, 0);
    fl <= 22'h00_0000;
    return_from_interrupt();
  endtask

  task automatic s_preempt();
    fl <= 22'h00_0001;
    take(16'h0003, 2, 0);
    fl <= 22'h00_0009;
    take(16'h001B, 2, 0);
    return_from_interrupt();
    take(16'h001B, 0, 0);
    fl <= 22'h00_0000;
    return_from_interrupt();
    chk(16'({in_service_high, in_service_low}), 16'h0001);
    return_from_interrupt();
    chk(16'({in_service_high, in_service_low}), 16'h0000);
  endtask

  task automatic s_stall();
    fl <= 22'h00_0010;
    take(16'h0023, 2, 3);
    fl <= 22'h00_0000;
    return_from_interrupt();
  endtask

  // six-cycle return then eight-cycle divide; the call starts 16 edges after the flag,
  // so detect, return, divide and call span 21 clocks
  task automatic s_worst();
    fl <= 22'h00_0001;
    take(16'h0003, 2, 0);
    @(negedge ref_clk);
    fl <= 22'h00_0002;
    busy_cmd <= 1'b1;
    repeat (5) @(negedge ref_clk);
    busy_cmd <= 1'b0;
    return_from_interrupt_cmd <= 1'b1;
    @(negedge ref_clk);
    busy_cmd <= 1'b1;
    return_from_interrupt_cmd <= 1'b0;
    repeat (7) @(negedge ref_clk);
    busy_cmd <= 1'b0;
    take(16'h000B, 3, 0);
    chk(16'(in_service_low), 16'h0001);
    fl <= 22'h00_0000;
    return_from_interrupt();
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge ref_clk);
    reset <= 1'b0;
    s_regs();
    s_each();
    s_gate();
    s_prio();
    s_preempt();
    s_stall();
    s_worst();
    results();
  end

  // whole run needs well under two thousand cycles
  initial begin
    repeat (8000) @(posedge ref_clk);
    fails = fails + 1;
    results();
  end
endmodule

bind tlic_top tlic_props tlic_props_inst (.ref_clk(ref_clk), .reset(reset),
  .src_flags(src_flags), .instr_done(instr_done), .instr_is_return_from_interrupt(instr_is_return_from_interrupt),
  .cpu_stall(cpu_stall), .call_active(call_active), .call_done(call_done),
  .call_vector(call_vector), .in_service_low(in_service_low),
  .in_service_high(in_service_high));
